// [verilog/strap_pkg.sv]
// strap_pkg: register map, field layout, reset values and timing counts
// for the management address strap latch.
// assumes a 40 MHz device clock.
package strap_pkg;
    localparam int          ADDR_W         = 5;
    localparam int          DATA_W         = 16;
    localparam int          NUM_STRAPS     = 5;
    localparam logic [4:0]  REG_PHY_CTRL   = 5'h19;
    // field positions inside phy_control_config
    localparam int          F_ADDR_LSB     = 0;
    localparam int          F_ADDR_MSB     = 4;
    localparam int          F_DUP_MODE     = 6;
    localparam int          F_TX_MODE      = 7;
    // bits 15:5 are software writable, 4:0 hold the latched address
    localparam logic [15:0] CTRL_WR_MASK   = 16'hffe0;
    localparam logic [15:0] CTRL_RST       = 16'h0040;
    localparam logic [4:0]  ISOLATE_ADDR   = 5'h00;
    localparam logic [15:0] UNMAPPED_DATA  = 16'h0000;
    // strap settle time after reset release before the pins are sampled
    localparam int          CLK_PERIOD_PS  = 25000;
    localparam int          SETTLE_NS      = 1000;
    localparam int          SETTLE_CYC     =
        (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          CNT_W          = 12;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_SETTLE,
        ST_RUN
    } strap_state_t;
endpackage

// [verilog/sync2_stage.sv]
// sync2_stage: two flip-flop synchroniser for a bus of independent levels.
// assumes each bit is a slow level; no word coherence is implied.
`timescale 1ns/1ps
module sync2_stage #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// [verilog/phy_address_strap_latch.sv]
// phy_address_strap_latch: strap sampling of the management address on
// dual-use indicator pins, the phy_control_config register and isolate.
// assumes board resistors set pin levels while the pins are undriven and
// that indicator sources come from logic on clk_i.
// assumes the register port and rst_n_i come from logic on clk_i.
// all outputs come straight from the state register.
// Contract
// - five straps give 32 management addresses
// - strapped address zero forces isolate after reset
// - strap bit n lands in register 19h bit n
// - reset pin active high, restarts initialization
// - reset returns all register bits to default
// - every reset resamples all straps again
// - after sampling, until the next reset, straps drive indicator outputs
// - register access works while isolated
`timescale 1ns/1ps
module phy_address_strap_latch #(
    parameter int SETTLE_CYCLES = strap_pkg::SETTLE_CYC
) (
    // clock and resets
    input  wire logic                              clk_i,
    input  wire logic                              rst_n_i,
    input  wire logic                              hw_reset_i,
    // shared strap and indicator pins
    input  wire logic [strap_pkg::NUM_STRAPS-1:0]  mgmt_addr_strap_i,
    output logic      [strap_pkg::NUM_STRAPS-1:0]  mgmt_addr_strap_o,
    output logic      [strap_pkg::NUM_STRAPS-1:0]  mgmt_addr_strap_oe_o,
    // indicator sources
    input  wire logic                              collision_indicator_i,
    input  wire logic                              transmit_indicator_i,
    input  wire logic                              disconnect_status_i,
    input  wire logic                              receive_indicator_i,
    input  wire logic                              link_indicator_i,
    input  wire logic                              duplex_status_i,
    input  wire logic                              polarity_status_i,
    // register port
    input  wire logic [strap_pkg::ADDR_W-1:0]      reg_addr_i,
    input  wire logic                              reg_rd_i,
    input  wire logic                              reg_wr_i,
    input  wire logic [strap_pkg::DATA_W-1:0]      reg_wdata_i,
    output logic      [strap_pkg::DATA_W-1:0]      reg_rdata_o,
    output logic                                   reg_ack_o,
    // latched strap status
    output logic      [strap_pkg::NUM_STRAPS-1:0]  mgmt_addr_o,
    output logic                                   isolate_o,
    output logic                                   strap_done_o
);
    import strap_pkg::*;

    localparam logic [CNT_W-1:0] SETTLE_LAST =
        CNT_W'(SETTLE_CYCLES - 1);

    typedef struct packed {
        strap_state_t          state;
        logic [CNT_W-1:0]      cnt;
        logic [NUM_STRAPS-1:0] addr;
        logic [DATA_W-1:0]     ctrl;
        logic                  isolate;
        logic                  done;
        logic [NUM_STRAPS-1:0] pin_out;
        logic [NUM_STRAPS-1:0] pin_oe;
        logic [DATA_W-1:0]     rdata;
        logic                  ack;
    } strap_regs_t;

    strap_regs_t           s_q;
    strap_regs_t           s_d;
    logic [NUM_STRAPS-1:0] strap_sync;
    logic                  hw_reset_sync;
    logic [NUM_STRAPS-1:0] ind_level;
    logic                  reg_req;
    logic                  reg_hit;
    logic                  settle_end;

    // one set of reset values for the state register
    localparam strap_regs_t S_RST = '{
        state:   ST_RESET,
        cnt:     '0,
        addr:    '0,
        ctrl:    CTRL_RST,
        isolate: 1'b0,
        done:    1'b0,
        pin_out: '0,
        pin_oe:  '0,
        rdata:   '0,
        ack:     1'b0
    };

    // register decode and end of the strap settle wait
    always_comb begin
        reg_req    = reg_rd_i || reg_wr_i;
        reg_hit    = (reg_addr_i == REG_PHY_CTRL);
        settle_end = (s_q.state == ST_SETTLE) && (s_q.cnt == SETTLE_LAST);
    end

    // pins and the reset pin come from outside the clock domain
    sync2_stage #(
        .W (NUM_STRAPS)
    ) u_strap_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i (mgmt_addr_strap_i),
        .sync_o  (strap_sync)
    );

    sync2_stage #(
        .W (1)
    ) u_reset_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i (hw_reset_i),
        .sync_o  (hw_reset_sync)
    );

    always_comb begin
        ind_level[0] = collision_indicator_i;
        if (s_q.ctrl[F_TX_MODE]) begin
            ind_level[1] = disconnect_status_i;
        end else begin
            ind_level[1] = transmit_indicator_i;
        end
        ind_level[2] = receive_indicator_i;
        ind_level[3] = link_indicator_i;
        if (s_q.ctrl[F_DUP_MODE]) begin
            ind_level[4] = duplex_status_i;
        end else begin
            ind_level[4] = polarity_status_i;
        end
    end

    always_comb begin
        s_d       = s_q;
        s_d.ack   = 1'b0;
        // rdata holds until the next request
        s_d.rdata = s_q.rdata;
        case (s_q.state)
            ST_RESET: begin
                // pins stay released until the reset pin falls
                s_d.pin_oe  = '0;
                s_d.pin_out = '0;
                s_d.cnt     = '0;
                if (!hw_reset_sync) begin
                    s_d.state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // pins float so the board resistors set them
                s_d.pin_oe = '0;
                if (settle_end) begin
                    // five strap levels form the address
                    // strap bit n into register bit n
                    s_d.addr    = strap_sync;
                    s_d.ctrl[F_ADDR_MSB:F_ADDR_LSB] = strap_sync;
                    s_d.isolate = (strap_sync == ISOLATE_ADDR);
                    s_d.done    = 1'b1;
                    s_d.state   = ST_RUN;
                end else begin
                    s_d.cnt = s_q.cnt + CNT_W'(1);
                end
            end
            ST_RUN: begin
                // pins now drive indicators
                // strap levels ignored until the next reset
                s_d.pin_oe  = '1;
                s_d.pin_out = ind_level;
            end
            default: begin
                s_d.state = ST_RESET;
            end
        endcase

        if (reg_req) begin
            s_d.ack = 1'b1;
            if (reg_hit) begin
                s_d.rdata = s_q.ctrl;
                if (reg_wr_i) begin
                    // address field not writable
                    // a latch in this cycle keeps its address
                    s_d.ctrl = (s_d.ctrl & ~CTRL_WR_MASK)
                             | (reg_wdata_i & CTRL_WR_MASK);
                end
            end else begin
                s_d.rdata = UNMAPPED_DATA;
            end
        end

        // active high reset restarts init
        // register port keeps answering meanwhile
        if (hw_reset_sync) begin
            s_d.state   = ST_RESET;
            s_d.cnt     = '0;
            s_d.pin_oe  = '0;
            s_d.pin_out = '0;
            s_d.ctrl    = CTRL_RST;
            s_d.addr    = '0;
            s_d.isolate = 1'b0;
            s_d.done    = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign mgmt_addr_strap_o    = s_q.pin_out;
    assign mgmt_addr_strap_oe_o = s_q.pin_oe;
    assign reg_rdata_o          = s_q.rdata;
    assign reg_ack_o            = s_q.ack;
    assign mgmt_addr_o          = s_q.addr;
    assign isolate_o            = s_q.isolate;
    assign strap_done_o         = s_q.done;
endmodule

// [verification/strap_board.sv]
// strap_board: board pull resistors on the five shared strap pins
// assumes the device enables are high while it drives a pin
`timescale 1ns/1ps
module strap_board (
    input  wire logic [4:0] oe_i,
    input  wire logic [4:0] drv_i,
    input  wire logic [4:0] lvl_i,
    output logic      [4:0] pin_o
);
    // undriven pins settle to the resistor level
    always_comb pin_o = (oe_i & drv_i) | (~oe_i & lvl_i);
endmodule

// [verification/phy_address_strap_latch_checker.sv]
// checker: port assertions for the strap latch
// assumes it is bound onto the strap latch top module
`timescale 1ns/1ps
module phy_address_strap_latch_checker
import strap_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        hw_reset_i,
    input wire logic        receive_indicator_i,
    input wire logic        reg_rd_i,
    input wire logic        reg_wr_i,
    input wire logic [4:0]  reg_addr_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        reg_ack_o,
    input wire logic [4:0]  mgmt_addr_o,
    input wire logic [4:0]  mgmt_addr_strap_o,
    input wire logic [4:0]  mgmt_addr_strap_oe_o,
    input wire logic        isolate_o,
    input wire logic        strap_done_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    req_ack_a: assert property ((reg_rd_i || reg_wr_i) |=> reg_ack_o)
        else $error("no ack after request");
    zero_isolate_a: assert property (strap_done_o |->
        isolate_o == (mgmt_addr_o == ISOLATE_ADDR)) else $error("isolate");
    addr_hold_a: assert property (strap_done_o && $past(strap_done_o) |->
        $stable(mgmt_addr_o)) else $error("address moved");
    pins_quiet_a: assert property (!strap_done_o |->
        mgmt_addr_strap_oe_o == 5'h00) else $error("pin driven early");
    rx_pin_a: assert property (mgmt_addr_strap_oe_o[2] &&
        $past(mgmt_addr_strap_oe_o[2]) |->
        mgmt_addr_strap_o[2] == $past(receive_indicator_i))
        else $error("receive pin wrong");
    hw_reset_a: assert property (hw_reset_i [*4] |->
        !strap_done_o && mgmt_addr_strap_oe_o == 5'h00)
        else $error("reset pin ignored");
    ctrl_addr_a: assert property (reg_ack_o && $stable(mgmt_addr_o) &&
        $past(reg_addr_i) == REG_PHY_CTRL |-> reg_rdata_o[4:0] == mgmt_addr_o)
        else $error("address field wrong");
    unmapped_a: assert property (reg_ack_o &&
        $past(reg_addr_i) != REG_PHY_CTRL |-> reg_rdata_o == UNMAPPED_DATA)
        else $error("unmapped data");
endmodule
bind phy_address_strap_latch phy_address_strap_latch_checker chk_u (.*);

// [verification/phy_address_strap_latch_test.sv]
// testbench: strap latch against a board model and a reference model
// assumes the package, design, board model and checker are compiled first
`timescale 1ns/1ps
module phy_address_strap_latch_test;
import strap_pkg::*;
logic clk_i = 0, rst_n_i = 0, hw_reset_i = 0, rd = 0, wr = 0, r;
logic [4:0] lvl = 0, pin, po, poe, ra = 0, ma;
logic [4:0] av[4] = '{5'h00, 5'h1f, 5'h0a, 5'h15};
logic [6:0] ind = 0;
logic [15:0] wd = 0, rdat, ctrl_hi;
logic ack, iso, done;
int err_count = 0, checks = 0, exp_a;
phy_address_strap_latch #(.SETTLE_CYCLES(4)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hw_reset_i(hw_reset_i),
    .mgmt_addr_strap_i(pin), .mgmt_addr_strap_o(po),
    .mgmt_addr_strap_oe_o(poe), .collision_indicator_i(ind[0]),
    .transmit_indicator_i(ind[1]), .disconnect_status_i(ind[5]),
    .receive_indicator_i(ind[2]), .link_indicator_i(ind[3]),
    .duplex_status_i(ind[4]), .polarity_status_i(ind[6]),
    .reg_addr_i(ra), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wd),
    .reg_rdata_o(rdat), .reg_ack_o(ack), .mgmt_addr_o(ma),
    .isolate_o(iso), .strap_done_o(done));
strap_board brd_u (.oe_i(poe), .drv_i(po), .lvl_i(lvl), .pin_o(pin));
initial forever #12.5 clk_i = ~clk_i;
always @(posedge clk_i) ind <= #1 7'($urandom);
task automatic print_verdict;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
        err_count++;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
endtask
task automatic reg_op(input logic w, input logic [4:0] a,
                      input logic [15:0] d);
    @(posedge clk_i) #1;
    {wr, rd, ra, wd} = {w, ~w, a, d};
    @(posedge clk_i) #1;
    {wr, rd} = 2'b00;
    chk(16'(ack), 16'h0001);
endtask
task automatic rd_ctrl;
    reg_op(1'b0, REG_PHY_CTRL, 16'h0000);
    chk(rdat, (ctrl_hi & CTRL_WR_MASK) | 16'(exp_a));
endtask
// model of the pin sources, chosen by the modelled mode bits
task automatic chk_pins;
    logic [4:0] e;
    @(posedge clk_i) #2;
    e = {ctrl_hi[F_DUP_MODE] ? ind[4] : ind[6], ind[3], ind[2],
         ctrl_hi[F_TX_MODE] ? ind[5] : ind[1], ind[0]};
    @(posedge clk_i) #2;
    chk(16'(pin), 16'(e));
    chk(16'(poe), 16'h001f);
endtask
task automatic boot(input logic [4:0] v, input logic hw);
    int n;
    lvl = v;
    if (hw) hw_reset_i = 1'b1;
    else rst_n_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1 {hw_reset_i, rst_n_i} = 2'b01;
    exp_a = v;
    ctrl_hi = CTRL_RST;
    for (n = 0; done !== 1'b1 && n < 60; n++) @(posedge clk_i) #1;
    if (n == 60) begin
        err_count++;
        print_verdict;
    end
    chk(16'(ma), 16'(exp_a));
    chk(16'(iso), 16'(v == ISOLATE_ADDR));
    rd_ctrl;
endtask
initial begin
    void'($urandom(61));
    boot(5'($urandom), 1'b0);
    for (int i = 0; i < 7; i++)
        boot(i < 4 ? av[i] : 5'($urandom), 1'b1);
    chk_pins;
    reg_op(1'b1, REG_PHY_CTRL, 16'hffff);
    ctrl_hi = 16'hffff;
    rd_ctrl;
    chk_pins;
    reg_op(1'b1, REG_PHY_CTRL, 16'h0080);
    ctrl_hi = 16'h0080;
    rd_ctrl;
    chk_pins;
    reg_op(1'b1, 5'h00, 16'h1234);
    reg_op(1'b0, 5'h00, 16'h0000);
    chk(rdat, UNMAPPED_DATA);
    repeat (20) @(posedge clk_i);
    @(posedge clk_i) #2 r = ind[2];
    @(posedge clk_i) #2 chk(16'(pin[2]), 16'(r));
    chk(16'(ma), 16'(exp_a));
    @(posedge clk_i) #1 boot(5'h0c, 1'b1);
    print_verdict;
end
endmodule
